//--- rtl/adcsq_regs.vh
/*
 Register map, field positions, reset values and conversion timing for the
 converter sequencer. Assumes a 32-bit register bus with one word per register.
*/
`ifndef ADCSQ_REGS_VH
`define ADCSQ_REGS_VH

// register indices; byte address is four times the index
`define ADCSQ_IDX_RESULT_LO 6'h04
`define ADCSQ_IDX_RESULT_HI 6'h05
`define ADCSQ_IDX_CTRL 6'h06
`define ADCSQ_IDX_CHSEL 6'h07

// control/status fields
`define ADCSQ_CTRL_EN 7
`define ADCSQ_CTRL_START 6
`define ADCSQ_CTRL_FREE 5
`define ADCSQ_CTRL_DONE 4
`define ADCSQ_CTRL_IE 3
`define ADCSQ_CTRL_DIV_LSB 0
`define ADCSQ_CTRL_DIV_W 3
`define ADCSQ_CHSEL_W 3

// reset values
`define ADCSQ_CTRL_RST 8'h00
`define ADCSQ_CHSEL_RST 3'h0
`define ADCSQ_RESULT_RST 10'h000

// conversion timing in ADC clock cycles
`define ADCSQ_NORM_CYCLES 5'd13
`define ADCSQ_DUMMY_EXTRA 5'd12
`define ADCSQ_SAMPLE_CYC 5'd1

// bus responses
`define ADCSQ_RESP_OKAY 2'h0
`define ADCSQ_RESP_SLVERR 2'h2

`endif

//--- rtl/adcsq_top.v
/*
 Conversion sequencer for a 10-bit successive-approximation converter,
 reached over AXI4-Lite. Assumes an analog core outside that follows the
 selected channel, holds its input on sample_o and presents its finished
 code on conv_data_i when the result is written.
*/
// What this block does
// - single or free-running mode by select bit
// - channel register picks one of eight inputs
// - first conversion after enable adds 12 cycles
// - start bit reads high until completion
// - channel change waits for current conversion end
// - result split over high and low registers
// - low read locks result until high read
// - done flag sets even when result dropped
// - prescaler runs only while enabled
// - conversion begins at next ADC clock edge
// - sample-and-hold 1.5 ADC cycles after begin
// - result written 13 ADC cycles after begin
// - single mode needs one extra idle cycle
// - free-running restarts right after each result
// - divider codes give 2,2,4,8,...,128
// - clearing enable aborts running conversion
// - done flag cleared by vector or one
`timescale 1ns/1ps
`include "adcsq_regs.vh"

module adcsq_top #(
  parameter RES_W = 10,
  parameter DIV_W = 7
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [RES_W-1:0] conv_data_i,
  input wire irq_ack_i,
  output wire [2:0] mux_sel_o,
  output wire sample_o,
  output wire conv_busy_o,
  output wire irq_o
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_GAP = 3'b100;
  localparam [7:0] CTRL_RST = `ADCSQ_CTRL_RST;

  // bus state
  reg aw_have_q;
  reg [5:0] aw_idx_q;
  reg w_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // control and status
  reg en_q;
  reg start_q;
  reg free_q;
  reg done_q;
  reg ie_q;
  reg [2:0] div_q;
  reg [2:0] chsel_q;

  // sequencer
  reg [2:0] state_q;
  reg [4:0] cyc_q;
  reg first_q;
  reg dummy_q;
  reg [2:0] act_ch_q;
  reg [RES_W-1:0] result_q;
  reg lock_q;
  reg sample_q;
  reg [DIV_W-1:0] pre_q;

  wire wr_fire;
  wire rd_fire;
  wire [5:0] ar_idx;
  wire wr_ctrl;
  wire wr_chsel;
  wire wr_mapped;
  wire rd_lo;
  wire rd_hi;
  wire ar_mapped;
  reg [DIV_W-1:0] div_last;
  wire tick_rise;
  wire tick_fall;
  wire [4:0] conv_len;
  wire [4:0] sample_at;
  wire conv_end;
  wire lock_now;
  wire done_clr;
  reg [31:0] rd_mux;

  // accept address and data independently, answer once both are held
  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready = ~w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign rd_fire = s_axi_arvalid & ~rvalid_q;
  assign ar_idx = s_axi_araddr[7:2];

  // registers hold 8 bits, so only the low byte lane matters
  assign wr_ctrl = wr_fire & wstrb_q[0] & (aw_idx_q == `ADCSQ_IDX_CTRL);
  assign wr_chsel = wr_fire & wstrb_q[0] & (aw_idx_q == `ADCSQ_IDX_CHSEL);
  assign wr_mapped = (aw_idx_q == `ADCSQ_IDX_CTRL) | (aw_idx_q == `ADCSQ_IDX_CHSEL) |
                     (aw_idx_q == `ADCSQ_IDX_RESULT_LO) | (aw_idx_q == `ADCSQ_IDX_RESULT_HI);
  assign ar_mapped = (ar_idx == `ADCSQ_IDX_CTRL) | (ar_idx == `ADCSQ_IDX_CHSEL) |
                     (ar_idx == `ADCSQ_IDX_RESULT_LO) | (ar_idx == `ADCSQ_IDX_RESULT_HI);
  assign rd_lo = rd_fire & (ar_idx == `ADCSQ_IDX_RESULT_LO);
  assign rd_hi = rd_fire & (ar_idx == `ADCSQ_IDX_RESULT_HI);

  always @* begin
    case (div_q)
      3'h0: div_last = 7'h01;
      3'h1: div_last = 7'h01;
      3'h2: div_last = 7'h03;
      3'h3: div_last = 7'h07;
      3'h4: div_last = 7'h0f;
      3'h5: div_last = 7'h1f;
      3'h6: div_last = 7'h3f;
      default: div_last = 7'h7f;
    endcase
  end

  // prescaler held in reset while disabled
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= 7'h00;
    end else if (!en_q || pre_q == div_last) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // rising edge of the divided clock at wrap, falling edge half way
  assign tick_rise = en_q & (pre_q == div_last);
  assign tick_fall = en_q & (pre_q == (div_last >> 1));

  // dummy conversion lengthens the first one
  assign conv_len = dummy_q ? (`ADCSQ_NORM_CYCLES + `ADCSQ_DUMMY_EXTRA) : `ADCSQ_NORM_CYCLES;
  assign sample_at = dummy_q ? (`ADCSQ_SAMPLE_CYC + `ADCSQ_DUMMY_EXTRA) : `ADCSQ_SAMPLE_CYC;
  // result at the last rising edge of the conversion
  assign conv_end = (state_q == ST_CONV) & tick_rise & (cyc_q + 5'd1 == conv_len);
  // a low read in the same cycle already freezes the pair
  assign lock_now = lock_q | rd_lo;
  // hardware vector or software one clears the flag
  assign done_clr = irq_ack_i | (wr_ctrl & wdata_q[`ADCSQ_CTRL_DONE]);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      aw_idx_q <= 6'h00;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `ADCSQ_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    case (ar_idx)
      `ADCSQ_IDX_CTRL: rd_mux[7:0] = {en_q, start_q, free_q, done_q, ie_q, div_q};
      `ADCSQ_IDX_CHSEL: rd_mux[2:0] = chsel_q;
      `ADCSQ_IDX_RESULT_LO: rd_mux[7:0] = result_q[7:0];
      `ADCSQ_IDX_RESULT_HI: rd_mux[RES_W-9:0] = result_q[RES_W-1:8];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ADCSQ_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= ar_mapped ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // low read locks, high read unlocks
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_q <= 1'b0;
    end else if (rd_hi) begin
      lock_q <= 1'b0;
    end else if (rd_lo) begin
      lock_q <= 1'b1;
    end
  end

  // flag set on every completion, set beats clear
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= CTRL_RST[`ADCSQ_CTRL_DONE];
    end else begin
      done_q <= conv_end | (done_q & ~done_clr);
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= `ADCSQ_RESULT_RST;
    end else if (conv_end && !lock_now) begin
      result_q <= conv_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q <= 1'b0;
      start_q <= 1'b0;
      free_q <= 1'b0;
      ie_q <= 1'b0;
      div_q <= 3'h0;
      chsel_q <= `ADCSQ_CHSEL_RST;
      state_q <= ST_IDLE;
      cyc_q <= 5'd0;
      first_q <= 1'b1;
      dummy_q <= 1'b0;
      act_ch_q <= `ADCSQ_CHSEL_RST;
      sample_q <= 1'b0;
    end else begin
      sample_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // begin on next divided clock edge
          if (tick_rise && start_q) begin
            state_q <= ST_CONV;
            cyc_q <= 5'd0;
            dummy_q <= first_q;
            first_q <= 1'b0;
            // channel taken only at conversion begin
            act_ch_q <= chsel_q;
          end
        end
        ST_CONV: begin
          // sample half a cycle after cycle one
          if (tick_fall && cyc_q == sample_at) begin
            sample_q <= 1'b1;
          end
          if (conv_end) begin
            // start clears when the conversion completes
            start_q <= 1'b0;
            cyc_q <= 5'd0;
            if (free_q) begin
              // back to back in free-running mode
              dummy_q <= 1'b0;
              act_ch_q <= chsel_q;
            end else begin
              // one idle ADC cycle in single mode
              state_q <= ST_GAP;
            end
          end else if (tick_rise) begin
            cyc_q <= cyc_q + 5'd1;
          end
        end
        ST_GAP: begin
          if (tick_rise) begin
            // pending start begins right after the gap
            if (start_q) begin
              state_q <= ST_CONV;
              cyc_q <= 5'd0;
              dummy_q <= first_q;
              first_q <= 1'b0;
              act_ch_q <= chsel_q;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // disabled converter aborts and rearms the dummy
      if (!en_q) begin
        state_q <= ST_IDLE;
        start_q <= 1'b0;
        first_q <= 1'b1;
        cyc_q <= 5'd0;
        sample_q <= 1'b0;
      end
      if (wr_ctrl) begin
        en_q <= wdata_q[`ADCSQ_CTRL_EN];
        free_q <= wdata_q[`ADCSQ_CTRL_FREE];
        ie_q <= wdata_q[`ADCSQ_CTRL_IE];
        div_q <= wdata_q[`ADCSQ_CTRL_DIV_LSB +: `ADCSQ_CTRL_DIV_W];
        // writing one together with the enable bit starts, zero has no effect
        if (wdata_q[`ADCSQ_CTRL_START] && wdata_q[`ADCSQ_CTRL_EN]) begin
          start_q <= 1'b1;
        end
      end
      if (wr_chsel) begin
        chsel_q <= wdata_q[`ADCSQ_CHSEL_W-1:0];
      end
    end
  end

  assign mux_sel_o = act_ch_q;
  assign sample_o = sample_q;
  assign conv_busy_o = (state_q == ST_CONV);
  // request while flag and interrupt enable both set
  assign irq_o = done_q & ie_q;

endmodule

//--- testbench/adcsq_monitor.sv
/*
 Assertions on the ports of adcsq_top.
 Assumes it is bound into adcsq_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module adcsq_monitor (
  input wire clk_i,
  input wire rst_n_i,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire irq_ack_i,
  input wire [2:0] mux_sel_o,
  input wire sample_o,
  input wire conv_busy_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_sample_pulse: assert property (sample_o |=> !sample_o)
    else $error("sample pulse longer than one cycle");
  chk_sample_busy: assert property (sample_o |-> conv_busy_o)
    else $error("sample outside a conversion");
  // at least 11.5 adc cycles of two clocks follow the sample
  chk_chan_hold: assert property (sample_o |=> $stable(mux_sel_o) [*8])
    else $error("channel moved during conversion");
  chk_irq_ack: assert property (irq_ack_i && irq_o && !conv_busy_o |=> !irq_o)
    else $error("interrupt not cleared by ack");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_busy: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && !s_axi_arready)
    else $error("read data dropped or address accepted");
  cover property (sample_o);
  cover property ($rose(irq_o));
  cover property (irq_ack_i && irq_o);
endmodule

bind adcsq_top adcsq_monitor u_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq_ack_i(irq_ack_i), .mux_sel_o(mux_sel_o), .sample_o(sample_o),
  .conv_busy_o(conv_busy_o), .irq_o(irq_o)
);

//--- testbench/tb_adc_conversion_sequencer.sv
/*
 Self-checking bench for adcsq_top driven over AXI4-Lite.
 Assumes the register header and the bound monitor are compiled alongside.
*/
`timescale 1ns/1ps
`include "adcsq_regs.vh"
module tb_adc_conversion_sequencer;
  localparam [7:0] A_LO = {`ADCSQ_IDX_RESULT_LO, 2'h0};
  localparam [7:0] A_HI = {`ADCSQ_IDX_RESULT_HI, 2'h0};
  localparam [7:0] A_CT = {`ADCSQ_IDX_CTRL, 2'h0};
  localparam [7:0] A_CH = {`ADCSQ_IDX_CHSEL, 2'h0};
  localparam [1:0] OK = `ADCSQ_RESP_OKAY;
  localparam [1:0] SE = `ADCSQ_RESP_SLVERR;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [9:0] conv = 10'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, irq_ack = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, busy, smp, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] msel;
  int err_total = 0, n_compared = 0, cyc = 0, c, nd;

  always #50 clk_i = ~clk_i;

  adcsq_top DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_data_i(conv), .irq_ack_i(irq_ack), .mux_sel_o(msel), .sample_o(smp),
    .conv_busy_o(busy), .irq_o(irq)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // ready is sampled at the falling edge: it cannot change before the next rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    b = 1'h0;
    while (!b) begin
      @(negedge clk_i);
      aw = awready;
      w = wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    chk("bresp", er, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
    logic ar, t;
    logic [1:0] r;
    logic [31:0] v;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    t = 1'h0;
    while (!t) begin
      @(negedge clk_i);
      ar = arready;
      t = rvalid;
      v = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ar) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    chk("rresp", er, r);
    chk("rdata", e, v);
  endtask

  // idle=1 waits for busy low, otherwise for a sample pulse
  task automatic wt(input bit idle, output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((idle ? busy !== 1'h0 : smp !== 1'h1) && n < 5000);
    if (n >= 5000) begin
      err_total++;
      $display("mismatch wait_limit expected below 5000 seen %0d", n);
    end
  endtask

  task end_sim;
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rd(A_CT, OK, 32'h0);
    rd(A_LO, OK, 32'h0);
    rd(A_HI, OK, 32'h0);
    rd(A_CH, OK, 32'h0);
    rd(8'h20, SE, 32'h0);
    wr(8'h20, 32'hff, SE);
    // every divider code, free running; each re-enable brings a dummy again
    for (int k = 0; k < 8; k++) begin
      nd = (k < 2) ? 2 : (1 << k);
      wr(A_CT, 32'h80 | k, OK);
      wr(A_CT, 32'he0 | k, OK);
      wt(0, c);
      chk("dummy_delay", 1, c + 3 >= 13 * nd && c <= 15 * nd);
      wt(0, c);
      chk("run_period", 13 * nd, c);
      wr(A_CT, 32'h10, OK);
      @(negedge clk_i);
      chk("abort", 0, busy);
    end
    @(posedge clk_i);
    nd = 64;
    conv <= 10'h2a5;
    wr(A_CH, 32'h3, OK);
    // code 6 divides by 64: 156 kHz from the 10 MHz clock
    wr(A_CT, 32'h8e, OK);
    wr(A_CT, 32'hce, OK);
    rd(A_CT, OK, 32'hce);
    // begin may lag the start by one adc cycle, so wait for the sample
    wt(0, c);
    wr(A_CH, 32'h5, OK);
    wt(1, c);
    chk("old_chan", 3, msel);
    rd(A_CT, OK, 32'h9e);
    chk("irq", 1, irq);
    rd(A_LO, OK, 32'ha5);
    rd(A_HI, OK, 32'h2);
    wr(A_CT, 32'h9e, OK);
    rd(A_CT, OK, 32'h8e);
    // low byte read locks, so the next result is lost
    rd(A_LO, OK, 32'ha5);
    conv <= 10'h15a;
    wr(A_CT, 32'hce, OK);
    wt(0, c);
    chk("norm_delay", 1, c >= 3 * nd / 2 && c <= 5 * nd / 2);
    wt(1, c);
    chk("new_chan", 5, msel);
    rd(A_CT, OK, 32'h9e);
    rd(A_HI, OK, 32'h2);
    rd(A_LO, OK, 32'ha5);
    rd(A_HI, OK, 32'h2);
    irq_ack <= 1'h1;
    @(posedge clk_i);
    irq_ack <= 1'h0;
    @(negedge clk_i);
    chk("irq_ack", 0, irq);
    repeat (80) @(negedge clk_i);
    chk("single_idle", 0, busy);
    wr(A_CT, 32'hce, OK);
    wt(0, c);
    wt(1, c);
    // start written inside the one-cycle gap after the result
    wr(A_CT, 32'hce, OK);
    wt(0, c);
    chk("gap_start", 1, c >= 2 * nd && c <= 5 * nd / 2);
    end_sim();
  end
endmodule
